//--- rtl/sbf_pkg.sv
// constants and types shared by the serial unit
// assumes one module clock; no register bus, all control bits are ports
package sbf_pkg;

    // ----------------------------------------------------------------
    // data and transfer shape
    // ----------------------------------------------------------------
    localparam int SBF_DATA_W = 8;
    localparam int SBF_EDGES = 16;
    localparam logic [3:0] SBF_LAST_EDGE = 4'hf;
    localparam logic [7:0] SBF_RX_RESET = 8'h00;
    localparam logic [7:0] SBF_TX_RESET = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SBF_CNT_W = 8;
    localparam logic [7:0] SBF_HALF_MIN = 8'h03;
    localparam int SBF_SYNC_W = 4;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SBF_IDLE = 3'b001,
        SBF_XFER = 3'b010,
        SBF_TAIL = 3'b100
    } sbf_state_t;

endpackage : sbf_pkg

//--- rtl/sbf_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/10ps
module sbf_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    if (W < 1) begin : g_bad_width
        $error("sbf_sync: W must be at least 1");
    end

    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= meta_next;
            q <= q_next;
        end
    end
endmodule : sbf_sync

//--- rtl/sbf_div.sv
// half serial-clock period enable divider
// assumes half_period is held stable while en is high
`timescale 1ns/10ps
module sbf_div #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control
    input wire logic en,
    input wire logic [CNT_W-1:0] half_period,
    // enable pulse
    output logic tick
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic tick_next;

    if (CNT_W < 2) begin : g_bad_width
        $error("sbf_div: CNT_W must be at least 2");
    end

    // stopped divider holds count at zero to save power
    always_comb begin
        cnt_next = '0;
        tick_next = 1'b0;
        if (en) begin
            if (cnt_reg >= half_period) begin
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule : sbf_div

//--- rtl/sbf_core.sv
// serial unit: single-wire mode, mode fault, low power, flags
// assumes processor strobes are one-cycle pulses on ref_clk
`timescale 1ns/10ps
module sbf_core
    import sbf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration levels
    input wire logic system_enable,
    input wire logic mode_fault_enable,
    input wire logic select_output_enable,
    input wire logic single_wire_select,
    input wire logic stop_in_wait,
    input wire logic clk_polarity,
    input wire logic clk_phase,
    input wire logic [SBF_CNT_W-1:0] half_period,
    // processor power state
    input wire logic wait_mode,
    input wire logic stop_mode,
    // processor strobes
    input wire logic ctrl1_wr,
    input wire logic ctrl1_master_in,
    input wire logic bidir_oe_wr,
    input wire logic bidir_oe_in,
    input wire logic status_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [SBF_DATA_W-1:0] data_wdata,
    // processor status
    output logic master_select,
    output logic bidir_output_enable,
    output logic mode_fault_flag,
    output logic transfer_done_flag,
    output logic tx_empty_flag,
    output logic [SBF_DATA_W-1:0] data_register,
    output logic irq,
    // serial pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe
);

    // ----------------------------------------------------------------
    // pin synchronisers and divider
    // ----------------------------------------------------------------
    logic [SBF_SYNC_W-1:0] pins_s;
    logic sck_s, mosi_s, miso_s, ss_n_s;
    logic tick;
    logic div_en;

    sbf_sync #(.W(SBF_SYNC_W)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({sck_i, mosi_i, miso_i, ss_n_i}),
        .q(pins_s)
    );
    assign sck_s = pins_s[3];
    assign mosi_s = pins_s[2];
    assign miso_s = pins_s[1];
    assign ss_n_s = pins_s[0];

    sbf_div #(.CNT_W(SBF_CNT_W)) u_div (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .en(div_en),
        .half_period(half_period),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // sequencer and flag state
    // ----------------------------------------------------------------
    sbf_state_t state_reg, state_next;
    logic [3:0] edge_reg, edge_next;
    logic [SBF_DATA_W-1:0] sh_reg, sh_next;
    logic [SBF_DATA_W-1:0] tx_reg, tx_next;
    logic [SBF_DATA_W-1:0] rx_reg, rx_next;
    logic [SBF_CNT_W-1:0] gap_reg, gap_next;
    logic [SBF_CNT_W-1:0] tail_reg, tail_next;
    logic out_reg, out_next;
    logic sck_reg, sck_next;
    logic sck_d_reg;
    logic master_select_reg, master_select_next;
    logic boe_reg, boe_next;
    logic mode_fault_flag_reg, mode_fault_flag_next;
    logic done_reg, done_next;
    logic txe_reg, txe_next;
    logic pend_reg, pend_next;
    logic arm_mode_fault_flag_reg, arm_mode_fault_flag_next;
    logic arm_done_reg, arm_done_next;
    logic arm_txe_reg, arm_txe_next;

    logic low_power, m_freeze, din, sck_edge, edge_ev, fault, finish;

    assign low_power = stop_mode | (wait_mode & stop_in_wait);
    assign m_freeze = master_select_reg & low_power;
    assign din = single_wire_select ? (master_select_reg ? mosi_s : miso_s)
                                    : (master_select_reg ? miso_s : mosi_s);
    assign sck_edge = sck_s ^ sck_d_reg;
    assign div_en = system_enable & master_select_reg & !m_freeze
                  & (state_reg != SBF_IDLE);
    assign edge_ev = (state_reg == SBF_XFER)
                   & (master_select_reg ? (tick & !m_freeze) : (sck_edge & !ss_n_s));
    assign fault = system_enable & master_select_reg & mode_fault_enable
                 & !select_output_enable & !ss_n_s;

    always_comb begin
        state_next = state_reg;
        edge_next = edge_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        gap_next = gap_reg;
        tail_next = tail_reg;
        out_next = out_reg;
        sck_next = sck_reg;
        master_select_next = master_select_reg;
        boe_next = boe_reg;
        mode_fault_flag_next = mode_fault_flag_reg;
        done_next = done_reg;
        txe_next = txe_reg;
        pend_next = pend_reg;
        arm_mode_fault_flag_next = arm_mode_fault_flag_reg;
        arm_done_next = arm_done_reg;
        arm_txe_next = arm_txe_reg;
        finish = 1'b0;

        // processor side stays live even when disabled
        if (status_rd) begin
            arm_mode_fault_flag_next = arm_mode_fault_flag_reg | mode_fault_flag_reg;
            arm_done_next = arm_done_reg | done_reg;
            arm_txe_next = arm_txe_reg | txe_reg;
        end
        if (ctrl1_wr) begin
            master_select_next = ctrl1_master_in;
            if (arm_mode_fault_flag_reg) begin
                mode_fault_flag_next = 1'b0;
                arm_mode_fault_flag_next = 1'b0;
            end
        end
        if (bidir_oe_wr) begin
            boe_next = bidir_oe_in;
        end
        if (data_rd && arm_done_reg) begin
            done_next = 1'b0;
            arm_done_next = 1'b0;
        end
        if (data_wr) begin
            tx_next = data_wdata;
            if (arm_txe_reg) begin
                txe_next = 1'b0;
                arm_txe_next = 1'b0;
            end
        end

        // slave gap timer measures the half period seen on the pin
        if (sck_edge) begin
            gap_next = '0;
        end else if (gap_reg != '1) begin
            gap_next = gap_reg + 1'b1;
        end

        if (!system_enable) begin
            state_next = SBF_IDLE;
            sck_next = clk_polarity;
        end else begin
            case (state_reg)
                SBF_IDLE: begin
                    sck_next = clk_polarity;
                    edge_next = '0;
                    if (master_select_reg && !mode_fault_flag_reg && !txe_reg && !m_freeze) begin
                        state_next = SBF_XFER;
                        sh_next = tx_reg;
                        out_next = tx_reg[SBF_DATA_W-1];
                        txe_next = 1'b1;
                    end else if (!master_select_reg && !mode_fault_flag_reg && ss_n_s) begin
                        // deselected slave reloads unless a copy is pending
                        if (!pend_reg) begin
                            sh_next = tx_reg;
                            out_next = tx_reg[SBF_DATA_W-1];
                        end
                    end else if (!master_select_reg && !mode_fault_flag_reg) begin
                        state_next = SBF_XFER;
                        txe_next = 1'b1;
                    end
                end
                SBF_XFER: begin
                    if (!master_select_reg && ss_n_s) begin
                        state_next = SBF_IDLE;
                    end else if (edge_ev) begin
                        if (master_select_reg) begin
                            sck_next = ~sck_reg;
                        end
                        if (edge_reg[0] == clk_phase) begin
                            sh_next = {sh_reg[SBF_DATA_W-2:0], din};
                        end else begin
                            out_next = sh_reg[SBF_DATA_W-1];
                        end
                        edge_next = edge_reg + 1'b1;
                        if (edge_reg == SBF_LAST_EDGE) begin
                            state_next = SBF_TAIL;
                            tail_next = gap_reg;
                        end
                    end
                end
                SBF_TAIL: begin
                    if (master_select_reg) begin
                        finish = tick & !m_freeze;
                    end else if (tail_reg == '0) begin
                        finish = 1'b1;
                    end else begin
                        tail_next = tail_reg - 1'b1;
                    end
                    if (finish) begin
                        state_next = SBF_IDLE;
                    end
                end
                default: begin
                    state_next = SBF_IDLE;
                end
            endcase
        end

        // completion, deferred for a slave in low power
        if (finish && !master_select_reg && low_power) begin
            pend_next = 1'b1;
        end else if ((finish || pend_reg) && !low_power) begin
            pend_next = 1'b0;
            if (!done_reg) begin
                rx_next = sh_reg;
                done_next = 1'b1;
            end
        end

        if (fault) begin
            mode_fault_flag_next = 1'b1;
            master_select_next = 1'b0;
            state_next = SBF_IDLE;
            sck_next = clk_polarity;
            pend_next = 1'b0;
            if (single_wire_select) begin
                boe_next = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SBF_IDLE;
            edge_reg <= '0;
            sh_reg <= SBF_TX_RESET;
            tx_reg <= SBF_TX_RESET;
            rx_reg <= SBF_RX_RESET;
            gap_reg <= '0;
            tail_reg <= '0;
            out_reg <= 1'b0;
            sck_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            master_select_reg <= 1'b0;
            boe_reg <= 1'b0;
            mode_fault_flag_reg <= 1'b0;
            done_reg <= 1'b0;
            txe_reg <= 1'b1;
            pend_reg <= 1'b0;
            arm_mode_fault_flag_reg <= 1'b0;
            arm_done_reg <= 1'b0;
            arm_txe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            edge_reg <= edge_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            gap_reg <= gap_next;
            tail_reg <= tail_next;
            out_reg <= out_next;
            sck_reg <= sck_next;
            sck_d_reg <= sck_s;
            master_select_reg <= master_select_next;
            boe_reg <= boe_next;
            mode_fault_flag_reg <= mode_fault_flag_next;
            done_reg <= done_next;
            txe_reg <= txe_next;
            pend_reg <= pend_next;
            arm_mode_fault_flag_reg <= arm_mode_fault_flag_next;
            arm_done_reg <= arm_done_next;
            arm_txe_reg <= arm_txe_next;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs and pin drivers
    // ----------------------------------------------------------------
    logic drive;
    logic sck_o_n, sck_oe_n, mosi_oe_n, miso_oe_n, ss_n_o_n, ss_n_oe_n;
    logic irq_n;

    assign drive = system_enable & !mode_fault_flag_next;

    always_comb begin
        sck_o_n = sck_next;
        sck_oe_n = drive & master_select_next;
        mosi_oe_n = 1'b0;
        miso_oe_n = 1'b0;
        if (master_select_next) begin
            mosi_oe_n = drive & (single_wire_select ? boe_next : 1'b1);
        end else if (!ss_n_s) begin
            miso_oe_n = drive & (single_wire_select ? boe_next : 1'b1);
        end
        ss_n_oe_n = drive & master_select_next & select_output_enable
                  & mode_fault_enable;
        ss_n_o_n = (state_next == SBF_IDLE);
        irq_n = system_enable
              & (mode_fault_flag_next | done_next | txe_next);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            master_select <= 1'b0;
            bidir_output_enable <= 1'b0;
            mode_fault_flag <= 1'b0;
            transfer_done_flag <= 1'b0;
            tx_empty_flag <= 1'b1;
            data_register <= SBF_RX_RESET;
            irq <= 1'b0;
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_o <= 1'b1;
            ss_n_oe <= 1'b0;
        end else begin
            master_select <= master_select_next;
            bidir_output_enable <= boe_next;
            mode_fault_flag <= mode_fault_flag_next;
            transfer_done_flag <= done_next;
            tx_empty_flag <= txe_next;
            data_register <= rx_next;
            irq <= irq_n;
            sck_o <= sck_o_n;
            sck_oe <= sck_oe_n;
            mosi_o <= out_next;
            mosi_oe <= mosi_oe_n;
            miso_o <= out_next;
            miso_oe <= miso_oe_n;
            ss_n_o <= ss_n_o_n;
            ss_n_oe <= ss_n_oe_n;
        end
    end

endmodule : sbf_core

//--- verif/sbf_core_asserts.sv
// checker for pin, flag and interrupt relations of the serial unit
// assumes a bind to sbf_core; sees only its ports
`timescale 1ns/10ps
module sbf_core_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration and strobes
    input wire logic system_enable,
    input wire logic mode_fault_enable,
    input wire logic select_output_enable,
    input wire logic single_wire_select,
    input wire logic ctrl1_wr,
    input wire logic data_rd,
    // status
    input wire logic master_select,
    input wire logic bidir_output_enable,
    input wire logic mode_fault_flag,
    input wire logic transfer_done_flag,
    input wire logic tx_empty_flag,
    input wire logic irq,
    // pin enables
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // ----
    // relations
    // ----
    AST_IRQ_OR: assert property ($past(rstn) |-> irq == ($past(system_enable)
        && (mode_fault_flag || transfer_done_flag || tx_empty_flag)))
        else $error("irq differs from enabled flag or");
    AST_FAULT_CAUSE: assert property ($rose(mode_fault_flag) |->
        $past(master_select) && $past(mode_fault_enable)
        && !$past(select_output_enable))
        else $error("mode fault raised without master fault cause");
    AST_FAULT_DROPS: assert property ($rose(mode_fault_flag) |->
        !master_select && !sck_oe && !mosi_oe && !miso_oe)
        else $error("mode fault left master or drivers on");
    AST_FAULT_BIDIR: assert property ($rose(mode_fault_flag) &&
        $past(single_wire_select) |-> !bidir_output_enable)
        else $error("mode fault kept single wire output enable");
    AST_FAULT_CLEAR: assert property ($fell(mode_fault_flag) |->
        $past(ctrl1_wr)) else $error("mode fault cleared without write");
    AST_DONE_CLEAR: assert property ($fell(transfer_done_flag) |->
        $past(data_rd)) else $error("done flag cleared without read");
    AST_SLAVE_QUIET: assert property (!master_select &&
        !$past(master_select) |-> !sck_oe && !ss_n_oe && !mosi_oe)
        else $error("slave drives clock, select or master data pin");
    AST_MASTER_NO_MISO: assert property (master_select &&
        $past(master_select) |-> !miso_oe)
        else $error("master drives slave data pin");
    AST_BIDIR_IN: assert property (master_select && $past(master_select)
        && $past(single_wire_select) && !bidir_output_enable
        && !$past(bidir_output_enable) |-> !mosi_oe)
        else $error("single wire pin driven with output enable clear");
    AST_OFF_QUIET: assert property (!$past(system_enable) &&
        !$past(system_enable, 2) && $past(rstn) |->
        !irq && !sck_oe && !mosi_oe && !miso_oe)
        else $error("disabled unit drives pins or irq");
    cover property ($rose(mode_fault_flag));
    cover property ($rose(transfer_done_flag) && !master_select);
    cover property ($rose(transfer_done_flag) && master_select);
endmodule : sbf_core_asserts

bind sbf_core sbf_core_asserts i_asserts (.ref_clk, .rstn, .system_enable,
    .mode_fault_enable, .select_output_enable, .single_wire_select,
    .ctrl1_wr, .data_rd, .master_select, .bidir_output_enable,
    .mode_fault_flag, .transfer_done_flag, .tx_empty_flag, .irq, .sck_oe,
    .mosi_oe, .miso_oe, .ss_n_oe);

//--- verif/sbf_peer_model.sv
// external serial slave, clock idle low, sample on rising edge
// assumes the unit drives clock and select; answers 8'h3c then counts up
`timescale 1ns/10ps
module sbf_peer_model (
    // serial pins
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    // last byte taken in
    output logic [7:0] rx_byte
);
    logic [7:0] tx_byte;
    logic [7:0] sh;
    int n;

    // ----
    // shifter
    // ----
    initial begin
        tx_byte = 8'h3c;
        rx_byte = 8'h00;
        miso = 1'b1;
        n = 0;
    end
    always @(negedge sel_n) begin
        sh = tx_byte;
        n = 0;
        miso = sh[7];
    end
    always @(posedge sck) if (!sel_n) begin
        rx_byte = {rx_byte[6:0], mosi};
        n++;
    end
    always @(negedge sck) if (!sel_n && n < 8) begin
        sh = sh << 1;
        miso = sh[7];
    end
    // released line shows the inverse, not a held value
    always @(posedge sel_n) begin
        miso = ~miso;
        if (n == 8) tx_byte = tx_byte + 8'h01;
    end
endmodule : sbf_peer_model

//--- verif/sbf_core_tb_top.sv
// self-checking bench for the serial unit with a slave peer
// assumes sbf_core, its checker bind and sbf_peer_model are compiled
`timescale 1ns/10ps
module sbf_core_tb_top;
    logic ref_clk, rstn, system_enable, mode_fault_enable;
    logic select_output_enable, single_wire_select, stop_in_wait;
    logic wait_mode, stop_mode, ctrl1_wr, ctrl1_master_in;
    logic bidir_oe_wr, bidir_oe_in, status_rd, data_rd, data_wr;
    logic [7:0] data_wdata, data_register, peer_rx, rx;
    logic master_select, bidir_output_enable, mode_fault_flag;
    logic transfer_done_flag, tx_empty_flag, irq, peer_miso;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
    logic tb_sck, tb_mosi, tb_ss_n, s, seen, bad_oe;
    logic sck_line, mosi_line, miso_line, ss_line;
    int bad_count, comparisons, moves, k;

    assign sck_line = sck_oe ? sck_o : tb_sck;
    assign mosi_line = mosi_oe ? mosi_o : tb_mosi;
    assign miso_line = miso_oe ? miso_o : peer_miso;
    assign ss_line = ss_n_oe ? ss_n_o : tb_ss_n;

    sbf_core i_dut (.ref_clk, .rstn, .system_enable, .mode_fault_enable,
        .select_output_enable, .single_wire_select, .stop_in_wait,
        .clk_polarity(1'b0), .clk_phase(1'b0), .half_period(8'h04),
        .wait_mode, .stop_mode, .ctrl1_wr, .ctrl1_master_in, .bidir_oe_wr,
        .bidir_oe_in, .status_rd, .data_rd, .data_wr, .data_wdata,
        .master_select, .bidir_output_enable, .mode_fault_flag,
        .transfer_done_flag, .tx_empty_flag, .data_register, .irq,
        .sck_i(sck_line), .sck_o, .sck_oe, .mosi_i(mosi_line), .mosi_o,
        .mosi_oe, .miso_i(miso_line), .miso_o, .miso_oe, .ss_n_i(ss_line),
        .ss_n_o, .ss_n_oe);
    sbf_peer_model i_peer (.sck(sck_line), .sel_n(ss_n_oe ? ss_n_o : 1'b1),
        .mosi(mosi_line), .miso(peer_miso), .rx_byte(peer_rx));

    // ----
    // tasks
    // ----
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // strobe bits: bidir oe, control one, status, data read, data write
    task cyc(input logic [4:0] st, input logic [7:0] v);
        @(negedge ref_clk);
        {bidir_oe_wr, ctrl1_wr, status_rd, data_rd, data_wr} = st;
        data_wdata = v;
        ctrl1_master_in = v[0];
        bidir_oe_in = v[0];
        @(negedge ref_clk);
        {bidir_oe_wr, ctrl1_wr, status_rd, data_rd, data_wr} = 5'h00;
    endtask : cyc
    task xfer(input logic [7:0] v);
        cyc(5'h04, 8'h00);
        cyc(5'h01, v);
    endtask : xfer
    task clr;
        cyc(5'h04, 8'h00);
        cyc(5'h02, 8'h00);
    endtask : clr
    task wait_done;
        for (int i = 0; i < 400 && transfer_done_flag !== 1'b1; i++)
            @(negedge ref_clk);
        chk("done flag", 8'h01, {7'h0, transfer_done_flag});
    endtask : wait_done
    // bench as master on the link; enters wait in mid byte
    task smaster(input logic [7:0] b);
        tb_ss_n = 1'b0;
        #64;
        for (int i = 7; i >= 0; i--) begin
            if (i == 4) wait_mode = 1'b1;
            tb_mosi = b[i];
            #32 tb_sck = 1'b1;
            rx = {rx[6:0], miso_line};
            #32 tb_sck = 1'b0;
        end
        #64 tb_ss_n = 1'b1;
        tb_mosi = ~tb_mosi;
    endtask : smaster

    // ----
    // clock, watchdog, sequence
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        bad_count++;
        stop_test;
    end
    initial begin
        {rstn, wait_mode, stop_mode, stop_in_wait, single_wire_select} = 5'h00;
        {ctrl1_wr, ctrl1_master_in, bidir_oe_wr, bidir_oe_in} = 4'h0;
        {status_rd, data_rd, data_wr, tb_sck, tb_mosi} = 5'h00;
        {system_enable, mode_fault_enable, select_output_enable} = 3'h7;
        data_wdata = 8'h00;
        tb_ss_n = 1'b1;
        rx = 8'h00;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        chk("data reg", 8'h00, data_register);
        chk("tx empty", 8'h01, {7'h0, tx_empty_flag});
        chk("irq", 8'h01, {7'h0, irq});
        cyc(5'h08, 8'h01);
        xfer(8'ha5);
        wait_done;
        chk("peer rx", 8'ha5, peer_rx);
        chk("data reg", 8'h3c, data_register);
        clr;
        chk("done flag", 8'h00, {7'h0, transfer_done_flag});
        xfer(8'h11);
        wait_done;
        xfer(8'h22);
        repeat (150) @(negedge ref_clk);
        chk("peer rx", 8'h22, peer_rx);
        chk("data reg", 8'h3d, data_register);
        clr;
        for (k = 0; k < 3; k++) begin
            stop_in_wait = (k == 1);
            xfer(8'(8'h40 + k));
            repeat (30) @(negedge ref_clk);
            wait_mode = (k < 2);
            stop_mode = (k == 2);
            s = sck_o;
            moves = 0;
            repeat (60) begin
                @(negedge ref_clk);
                if (sck_o !== s) moves++;
                s = sck_o;
            end
            {wait_mode, stop_mode} = 2'b00;
            chk("frozen", {7'h0, k > 0}, {7'h0, moves == 0});
            wait_done;
            chk("peer rx", 8'(8'h40 + k), peer_rx);
            clr;
        end
        stop_in_wait = 1'b0;
        single_wire_select = 1'b1;
        cyc(5'h10, 8'h01);
        chk("bidir oe", 8'h01, {7'h0, bidir_output_enable});
        xfer(8'h81);
        {seen, bad_oe} = 2'b00;
        repeat (120) begin
            @(negedge ref_clk);
            seen |= mosi_oe;
            bad_oe |= miso_oe;
        end
        chk("mosi drive", 8'h01, {7'h0, seen});
        chk("miso drive", 8'h00, {7'h0, bad_oe});
        wait_done;
        clr;
        select_output_enable = 1'b0;
        tb_ss_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk("fault", 8'h01, {7'h0, mode_fault_flag});
        chk("master", 8'h00, {7'h0, master_select});
        chk("bidir oe", 8'h00, {7'h0, bidir_output_enable});
        chk("drivers", 8'h00, {6'h0, sck_oe, mosi_oe});
        chk("irq", 8'h01, {7'h0, irq});
        tb_ss_n = 1'b1;
        cyc(5'h08, 8'h01);
        chk("fault", 8'h01, {7'h0, mode_fault_flag});
        cyc(5'h04, 8'h00);
        cyc(5'h08, 8'h01);
        chk("fault", 8'h00, {7'h0, mode_fault_flag});
        chk("master", 8'h01, {7'h0, master_select});
        mode_fault_enable = 1'b0;
        tb_ss_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk("fault", 8'h00, {7'h0, mode_fault_flag});
        tb_ss_n = 1'b1;
        single_wire_select = 1'b0;
        stop_in_wait = 1'b1;
        cyc(5'h08, 8'h00);
        xfer(8'h5a);
        smaster(8'hc3);
        repeat (20) @(negedge ref_clk);
        chk("done flag", 8'h00, {7'h0, transfer_done_flag});
        wait_mode = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk("done flag", 8'h01, {7'h0, transfer_done_flag});
        chk("data reg", 8'hc3, data_register);
        chk("slave tx", 8'h5a, rx);
        clr;
        system_enable = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irq});
        cyc(5'h08, 8'h01);
        chk("master", 8'h01, {7'h0, master_select});
        stop_test;
    end
endmodule : sbf_core_tb_top
